/* rtl/lcd_ctrl_device.sv */
/*
  Controller end of the host port. Catches host cycles, asks the
  internal memory/register arbiter for the resource, holds ready low
  until the arbiter answers, then releases it.
  Assumes the host pins are asynchronous to clk, the arbiter sits on
  clk and answers a held request with a one-cycle grant.
*/
`timescale 1ns/1ps
module lcd_ctrl_device
  import lcd_port_pkg::*;
(
  input  wire logic                                clk,
  input  wire logic                                rst_b,
  lcd_port_if.dev                                  bus,
  input  wire logic [lcd_port_pkg::STRAP_W-1:0]    config_straps,
  input  wire logic                                bus_status_strap,
  output logic                                     res_req,
  output logic                                     res_write,
  output logic      [lcd_port_pkg::ADDR_W-1:0]     res_addr,
  output logic      [1:0]                          res_lanes,
  output logic      [lcd_port_pkg::DATA_W-1:0]     res_wdata,
  input  wire logic                                res_grant,
  input  wire logic [lcd_port_pkg::DATA_W-1:0]     res_rdata,
  output logic                                     cfg_valid,
  output logic                                     mode_generic,
  output logic                                     big_endian
);

  // Pin synchronisers, two stages each
  logic [ADDR_W-1:0]  addr_m, addr_s;     // Address
  logic [DATA_W-1:0]  data_m, data_s;     // Write data
  logic               cs_m, cs_s;         // Select, active low
  logic               rd_m, rd_s;         // Read strobe, active low
  logic               wr_m, wr_s;         // Write strobe, active low
  logic               hbe_m, hbe_s;       // High byte enable
  logic [STRAP_W-1:0] strap_m, strap_s;   // Straps
  logic               bs_m, bs_s;         // Bus status strap

  // Strap capture state
  logic [1:0]         strap_cnt;          // Edges since release
  logic [1:0]         next_strap_cnt;
  logic               next_cfg_valid;
  logic               next_mode_generic;
  logic               next_big_endian;

  // Cycle state
  dev_state_t         state;
  dev_state_t         next_state;
  logic               next_res_req;
  logic               next_res_write;
  logic [ADDR_W-1:0]  next_res_addr;
  logic [1:0]         next_res_lanes;
  logic [DATA_W-1:0]  next_res_wdata;
  logic [DATA_W-1:0]  dout;               // Read data to pins
  logic [DATA_W-1:0]  next_dout;
  logic               dout_oe_n;          // Data drive, low drives
  logic               next_dout_oe_n;
  logic               rdy_oe_n;           // Ready pull, low pulls
  logic               next_rdy_oe_n;
  logic               ack16_n;            // Word capability ack
  logic               next_ack16_n;

  // Start condition, sampled values only
  logic               selected;           // Select seen low
  logic               one_strobe;         // Exactly one strobe low

  // Pins pass two flops before any logic reads them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_m  <= '0;
      addr_s  <= '0;
      data_m  <= '0;
      data_s  <= '0;
      cs_m    <= 1'b1;
      cs_s    <= 1'b1;
      rd_m    <= 1'b1;
      rd_s    <= 1'b1;
      wr_m    <= 1'b1;
      wr_s    <= 1'b1;
      hbe_m   <= 1'b1;
      hbe_s   <= 1'b1;
      strap_m <= '0;
      strap_s <= '0;
      bs_m    <= 1'b0;
      bs_s    <= 1'b0;
    end else begin
      addr_m  <= bus.addr;
      addr_s  <= addr_m;
      data_m  <= bus.data;
      data_s  <= data_m;
      cs_m    <= bus.display_ctrl_select_n;
      cs_s    <= cs_m;
      rd_m    <= bus.mem_read_strobe_n;
      rd_s    <= rd_m;
      wr_m    <= bus.mem_write_strobe_n;
      wr_s    <= wr_m;
      hbe_m   <= bus.high_byte_enable_n;
      hbe_s   <= hbe_m;
      strap_m <= config_straps;
      strap_s <= strap_m;
      bs_m    <= bus_status_strap;
      bs_s    <= bs_m;
    end
  end

  // Strap capture: straps cannot be taken under the async reset,
  // so they are caught once the synchronisers hold post-release values
  always_comb begin
    next_strap_cnt    = strap_cnt;
    next_cfg_valid    = cfg_valid;
    next_mode_generic = mode_generic;
    next_big_endian   = big_endian;
    if (!cfg_valid) begin
      if (strap_cnt == STRAP_DELAY) begin
        next_cfg_valid    = 1'b1;
        next_mode_generic = (strap_s[2:0] == STRAP_GENERIC) &&
                            (bs_s == STATUS_GEN2);
        next_big_endian   = strap_s[STRAP_ENDIAN];
      end else begin
        next_strap_cnt = strap_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_cnt    <= '0;
      cfg_valid    <= 1'b0;
      mode_generic <= 1'b0;
      big_endian   <= 1'b0;
    end else begin
      strap_cnt    <= next_strap_cnt;
      cfg_valid    <= next_cfg_valid;
      mode_generic <= next_mode_generic;
      big_endian   <= next_big_endian;
    end
  end

  // Whole 128 Kbyte window rides on the one select; strobes
  // without it are ignored
  assign selected   = cfg_valid && mode_generic && !cs_s;
  assign one_strobe = rd_s ^ wr_s;

  // Cycle engine: next values
  always_comb begin
    next_state     = state;
    next_res_req   = res_req;
    next_res_write = res_write;
    next_res_addr  = res_addr;
    next_res_lanes = res_lanes;
    next_res_wdata = res_wdata;
    next_dout      = dout;
    next_dout_oe_n = dout_oe_n;
    next_rdy_oe_n  = rdy_oe_n;
    // Acknowledge tracks the select, only in generic mode
    next_ack16_n   = !selected;
    unique case (state)
      D_IDLE: begin
        // Both strobes low at once is not a cycle; wait it out
        if (selected && one_strobe) begin
          next_rdy_oe_n  = 1'b0;
          next_res_req   = 1'b1;
          next_res_write = !wr_s;
          next_res_addr  = addr_s;
          next_res_lanes = lane_enables(hbe_s, addr_s[0]);
          next_res_wdata = big_endian ? swap_bytes(data_s) : data_s;
          next_state     = D_ARB;
        end
      end
      D_ARB: begin
        // Ready held low until the arbiter grants the resource
        if (res_grant) begin
          next_res_req = 1'b0;
          if (res_write) begin
            // Write data were captured at cycle start
            next_rdy_oe_n = 1'b1;
            next_state    = D_HOLD;
          end else begin
            next_dout      = big_endian ? swap_bytes(res_rdata) : res_rdata;
            next_dout_oe_n = 1'b0;
            next_state     = D_DATA;
          end
        end
      end
      D_DATA: begin
        // Data stood on the pins one cycle before ready lets go
        next_rdy_oe_n = 1'b1;
        next_state    = D_HOLD;
      end
      D_HOLD: begin
        // Cycle ends when the strobe or select goes away
        if (cs_s || (rd_s && wr_s)) begin
          next_dout_oe_n = 1'b1;
          next_state     = D_IDLE;
        end
      end
    endcase
  end

  // Cycle engine: registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= D_IDLE;
      res_req   <= 1'b0;
      res_write <= 1'b0;
      res_addr  <= '0;
      res_lanes <= '0;
      res_wdata <= '0;
      dout      <= '0;
      dout_oe_n <= 1'b1;
      rdy_oe_n  <= 1'b1;
      ack16_n   <= 1'b1;
    end else begin
      state     <= next_state;
      res_req   <= next_res_req;
      res_write <= next_res_write;
      res_addr  <= next_res_addr;
      res_lanes <= next_res_lanes;
      res_wdata <= next_res_wdata;
      dout      <= next_dout;
      dout_oe_n <= next_dout_oe_n;
      rdy_oe_n  <= next_rdy_oe_n;
      ack16_n   <= next_ack16_n;
    end
  end

  // Pin drives, all from flops; ready only ever pulls low
  assign bus.dev_data           = dout;
  assign bus.dev_data_oe_n      = dout_oe_n;
  assign bus.ready_out          = 1'b0;
  assign bus.ready_oe_n         = rdy_oe_n;
  assign bus.word_capable_ack_n = ack16_n;

endmodule

/* rtl/lcd_port_pkg.sv */
/*
  Shared constants, state encodings and helpers for the display
  controller host port, both the controller end and the host end.
  Assumes one 100 MHz clock per end and pins that cross between the
  two ends asynchronously.
*/
// Behaviour
// - Controller decodes one 128 Kbyte window, one select.
// - Host maps window at 133E0000h to 133FFFFFh.
// - Host reserves a dedicated block with own select.
// - Host drives select low for accesses in block.
// - Host asserts only one strobe per cycle.
// - Controller pulls ready low; host waits meanwhile.
// - Host upper byte enable low means word transfer.
// - Controller acknowledges sixteen-bit capability, active low.
// - Both ends follow ISA memory-cycle signalling.
// - Ready stays low until resource arbitration completes.
// - Straps latched after reset select mode, endianness.
// - High byte enable qualifies upper byte, both directions.
package lcd_port_pkg;

  localparam int ADDR_W  = 17;               // Address pins
  localparam int DATA_W  = 16;               // Data pins
  localparam int STRAP_W = 4;                // Configuration straps
  localparam int CNT_W   = 4;                // Host delay counter width

  // Host memory window, 128 Kbytes
  localparam logic [31:0] WIN_BASE = 32'h133E_0000;
  localparam logic [31:0] WIN_MASK = 32'h0001_FFFF;

  // Strap decode: low three straps all ones plus bus status high
  localparam logic [2:0] STRAP_GENERIC = 3'h7;
  localparam logic       STATUS_GEN2   = 1'h1;
  localparam int         STRAP_ENDIAN  = 3;  // Strap bit for big endian
  localparam logic [1:0] STRAP_DELAY   = 2'h2; // Edges after release

  // Host timing, in clock cycles; covers two syncs on each end
  localparam logic [CNT_W-1:0] READY_SETTLE = 4'h6;
  localparam logic [CNT_W-1:0] IDLE_GAP     = 4'h6;

  // Controller end states
  typedef enum logic [3:0] {
    D_IDLE = 4'b0001,
    D_ARB  = 4'b0010,
    D_DATA = 4'b0100,
    D_HOLD = 4'b1000
  } dev_state_t;

  // Host end states
  typedef enum logic [4:0] {
    H_IDLE   = 5'b00001,
    H_SETUP  = 5'b00010,
    H_STROBE = 5'b00100,
    H_WAIT   = 5'b01000,
    H_GAP    = 5'b10000
  } host_state_t;

  // Byte order swap for big endian hosts
  function automatic logic [DATA_W-1:0] swap_bytes(input logic [DATA_W-1:0] d);
    return {d[7:0], d[15:8]};
  endfunction

  // Lane enables: upper lane by high byte enable, lower lane by A0
  function automatic logic [1:0] lane_enables(input logic hbe_n, input logic a0);
    return {~hbe_n, ~a0};
  endfunction

endpackage

/* rtl/lcd_port_if.sv */
/*
  Pin bundle between the host end and the controller end.
  Assumes each end drives only its own copy of a shared pin; the
  wire levels are resolved here, with pull-ups on idle lines.
*/
`timescale 1ns/1ps
interface lcd_port_if;
  import lcd_port_pkg::*;

  logic [ADDR_W-1:0] addr;                  // Address from host
  logic [DATA_W-1:0] host_data;             // Host data drive
  logic              host_data_oe_n;        // Host drives data when low
  logic [DATA_W-1:0] dev_data;              // Controller data drive
  logic              dev_data_oe_n;         // Controller drives when low
  logic [DATA_W-1:0] data;                  // Resolved data bus
  logic              upper_byte_enable_n;   // Host word/byte select
  logic              high_byte_enable_n;    // Same wire, controller view
  logic              display_ctrl_select_n; // Window select
  logic              mem_read_strobe_n;     // Read strobe
  logic              mem_write_strobe_n;    // Write strobe
  logic              ready_out;             // Controller ready drive value
  logic              ready_oe_n;            // Controller pulls when low
  logic              cycle_ready;           // Resolved ready, pulled up
  logic              word_capable_ack_n;    // Sixteen-bit acknowledge

  // Undriven data floats high through the pull-ups
  assign data = !dev_data_oe_n  ? dev_data :
                !host_data_oe_n ? host_data : 16'hFFFF;
  // Open-drain ready line
  assign cycle_ready = ready_oe_n ? 1'b1 : ready_out;
  assign high_byte_enable_n = upper_byte_enable_n;

  modport dev (
    input  addr, data, high_byte_enable_n, display_ctrl_select_n,
    input  mem_read_strobe_n, mem_write_strobe_n,
    output dev_data, dev_data_oe_n, ready_out, ready_oe_n,
    output word_capable_ack_n
  );

  modport host (
    input  data, cycle_ready, word_capable_ack_n,
    output addr, host_data, host_data_oe_n, upper_byte_enable_n,
    output display_ctrl_select_n, mem_read_strobe_n, mem_write_strobe_n
  );
endinterface

/* rtl/lcd_host_port.sv */
/*
  Host end of the display controller port. Turns user commands into
  memory cycles inside the reserved window and waits on ready.
  Assumes the controller pins are asynchronous to clk.
*/
`timescale 1ns/1ps
module lcd_host_port
  import lcd_port_pkg::*;
(
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  lcd_port_if.host                              bus,
  input  wire logic                             cmd_valid,
  input  wire logic                             cmd_write,
  input  wire logic                             cmd_word,
  input  wire logic [31:0]                      cmd_addr,
  input  wire logic [lcd_port_pkg::DATA_W-1:0]  cmd_wdata,
  output logic                                  cmd_ready,
  output logic                                  rsp_valid,
  output logic                                  rsp_miss,
  output logic                                  rsp_wide,
  output logic      [lcd_port_pkg::DATA_W-1:0]  rsp_rdata
);

  // Synchronisers for controller pins
  logic [DATA_W-1:0] data_m, data_s;
  logic              rdy_m, rdy_s;
  logic              ack_m, ack_s;

  host_state_t       state;
  host_state_t       next_state;
  logic [CNT_W-1:0]  cnt;                  // Settle and gap counter
  logic [CNT_W-1:0]  next_cnt;
  logic [ADDR_W-1:0] addr;                 // Address pins
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] wdata;                // Write data pins
  logic [DATA_W-1:0] next_wdata;
  logic              wdata_oe_n;
  logic              next_wdata_oe_n;
  logic              ube_n;
  logic              next_ube_n;
  logic              cs_n;
  logic              next_cs_n;
  logic              rd_n;
  logic              next_rd_n;
  logic              wr_n;
  logic              next_wr_n;
  logic              is_write;             // Current cycle direction
  logic              next_is_write;
  logic              next_cmd_ready;
  logic              next_rsp_valid;
  logic              next_rsp_miss;
  logic              next_rsp_wide;
  logic [DATA_W-1:0] next_rsp_rdata;
  logic              in_window;

  // Pins pass two flops before any logic reads them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_m <= '0;
      data_s <= '0;
      rdy_m  <= 1'b1;
      rdy_s  <= 1'b1;
      ack_m  <= 1'b1;
      ack_s  <= 1'b1;
    end else begin
      data_m <= bus.data;
      data_s <= data_m;
      rdy_m  <= bus.cycle_ready;
      rdy_s  <= rdy_m;
      ack_m  <= bus.word_capable_ack_n;
      ack_s  <= ack_m;
    end
  end

  // Window decode against the fixed 128 Kbyte block
  assign in_window = (cmd_addr & ~WIN_MASK) == WIN_BASE;

  // Cycle sequencer: next values
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_addr       = addr;
    next_wdata      = wdata;
    next_wdata_oe_n = wdata_oe_n;
    next_ube_n      = ube_n;
    next_cs_n       = cs_n;
    next_rd_n       = rd_n;
    next_wr_n       = wr_n;
    next_is_write   = is_write;
    next_cmd_ready  = cmd_ready;
    next_rsp_valid  = 1'b0;
    next_rsp_miss   = rsp_miss;
    next_rsp_wide   = rsp_wide;
    next_rsp_rdata  = rsp_rdata;
    unique case (state)
      H_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          if (in_window) begin
            next_cmd_ready  = 1'b0;
            next_addr       = cmd_addr[ADDR_W-1:0];
            next_cs_n       = 1'b0;
            next_ube_n      = !cmd_word;
            next_is_write   = cmd_write;
            next_wdata      = cmd_wdata;
            next_wdata_oe_n = !cmd_write;
            next_state      = H_SETUP;
          end else begin
            // Outside the window no cycle is run
            next_rsp_valid = 1'b1;
            next_rsp_miss  = 1'b1;
          end
        end
      end
      H_SETUP: begin
        // Address and select settle one cycle before the strobe
        next_rd_n  = is_write;
        next_wr_n  = !is_write;
        next_cnt   = READY_SETTLE;
        next_state = H_STROBE;
      end
      H_STROBE: begin
        // Give the controller time to pull ready before looking
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_state = H_WAIT;
        end
      end
      H_WAIT: begin
        // Cycle stretched for as long as ready stays low
        if (rdy_s) begin
          next_rd_n       = 1'b1;
          next_wr_n       = 1'b1;
          next_cs_n       = 1'b1;
          next_wdata_oe_n = 1'b1;
          next_rsp_valid  = 1'b1;
          next_rsp_miss   = 1'b0;
          next_rsp_wide   = !ack_s;
          next_rsp_rdata  = is_write ? rsp_rdata : data_s;
          next_cnt        = IDLE_GAP;
          next_state      = H_GAP;
        end
      end
      H_GAP: begin
        // Lets the controller see the cycle end before the next one
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_cmd_ready = 1'b1;
          next_state     = H_IDLE;
        end
      end
    endcase
  end

  // Cycle sequencer: registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= H_IDLE;
      cnt        <= '0;
      addr       <= '0;
      wdata      <= '0;
      wdata_oe_n <= 1'b1;
      ube_n      <= 1'b1;
      cs_n       <= 1'b1;
      rd_n       <= 1'b1;
      wr_n       <= 1'b1;
      is_write   <= 1'b0;
      cmd_ready  <= 1'b1;
      rsp_valid  <= 1'b0;
      rsp_miss   <= 1'b0;
      rsp_wide   <= 1'b0;
      rsp_rdata  <= '0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      addr       <= next_addr;
      wdata      <= next_wdata;
      wdata_oe_n <= next_wdata_oe_n;
      ube_n      <= next_ube_n;
      cs_n       <= next_cs_n;
      rd_n       <= next_rd_n;
      wr_n       <= next_wr_n;
      is_write   <= next_is_write;
      cmd_ready  <= next_cmd_ready;
      rsp_valid  <= next_rsp_valid;
      rsp_miss   <= next_rsp_miss;
      rsp_wide   <= next_rsp_wide;
      rsp_rdata  <= next_rsp_rdata;
    end
  end

  // Pin drives from flops
  assign bus.addr                  = addr;
  assign bus.host_data             = wdata;
  assign bus.host_data_oe_n        = wdata_oe_n;
  assign bus.upper_byte_enable_n   = ube_n;
  assign bus.display_ctrl_select_n = cs_n;
  assign bus.mem_read_strobe_n     = rd_n;
  assign bus.mem_write_strobe_n    = wr_n;

endmodule

/* bench/lcd_port_checker.sv */
/*
  Pin-level checks on the bus between host end and controller end.
  Assumes one clock, async active-low reset, and that the bench keeps
  arbiter grants at least two cycles after a request.
*/
`timescale 1ns/1ps
module lcd_port_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] data,
  input wire logic        display_ctrl_select_n,
  input wire logic        mem_read_strobe_n,
  input wire logic        mem_write_strobe_n,
  input wire logic        cycle_ready,
  input wire logic        word_capable_ack_n,
  input wire logic        dev_data_oe_n,
  input wire logic        host_data_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Either strobe starting a cycle
  sequence s_strobe_fall;
    $fell(mem_read_strobe_n & mem_write_strobe_n);
  endsequence
  // Acknowledged cycle well under way
  sequence s_cycle_live;
    s_strobe_fall ##4 !word_capable_ack_n;
  endsequence

  AST_ONE_STROBE: assert property (mem_read_strobe_n || mem_write_strobe_n)
    else $error("both strobes low");
  AST_STROBE_SELECTED: assert property
    (!(mem_read_strobe_n && mem_write_strobe_n) |-> !display_ctrl_select_n)
    else $error("strobe without select");
  AST_READY_WAIT: assert property (s_cycle_live |-> !cycle_ready)
    else $error("no wait state inserted");
  AST_HOLD_STROBE: assert property
    (!(mem_read_strobe_n && mem_write_strobe_n) && !cycle_ready
     |=> !(mem_read_strobe_n && mem_write_strobe_n))
    else $error("strobe dropped while waiting");
  AST_READ_DATA_READY: assert property
    ($rose(cycle_ready) && !mem_read_strobe_n |-> !dev_data_oe_n)
    else $error("ready before read data");
  AST_DATA_RELEASE: assert property
    ($rose(mem_read_strobe_n) |-> ##[1:4] dev_data_oe_n)
    else $error("read data not released");
  AST_DEV_QUIET_ON_WRITE: assert property
    (!mem_write_strobe_n |-> dev_data_oe_n)
    else $error("controller drives during write");
  AST_HOST_QUIET_ON_READ: assert property (!mem_read_strobe_n |-> host_data_oe_n)
    else $error("host drives during read");
  AST_WRITE_DATA_STABLE: assert property
    (!mem_write_strobe_n && !$past(mem_write_strobe_n) |-> $stable(data))
    else $error("write data moved");
  AST_ACK_DROP: assert property
    ($rose(display_ctrl_select_n) |-> ##[1:4] word_capable_ack_n)
    else $error("ack held after deselect");
endmodule

/* bench/tb_top.sv */
/*
  Bench joining host end and controller end through the pin bundle.
  Assumes a simple arbiter model here that grants after gnt_dly cycles
  and returns a read pattern derived from the address.
*/
`timescale 1ns/1ps
module tb_top;
  import lcd_port_pkg::*;
  localparam logic [15:0] RD_PAT = 16'hC3C3;     // Read pattern seed
  logic        clk = 1'b0;                       // System clock
  logic        rst_b = 1'b0;                     // Reset, active low
  logic [3:0]  straps = 4'h7;                    // Configuration straps
  logic        status_strap = 1'b1;              // Bus status strap
  logic        cmd_valid = 1'b0, cmd_write = 1'b0, cmd_word = 1'b0;
  logic [31:0] cmd_addr = 32'h0000_0000;         // Command address
  logic [15:0] cmd_wdata = 16'h0000;             // Command data
  logic        cmd_ready, rsp_valid, rsp_miss, rsp_wide;
  logic [15:0] rsp_rdata, res_wdata, res_rdata = 16'h0000, last_wdata;
  logic        res_req, res_write, res_grant = 1'b0, last_write, rdy_at_gnt;
  logic [16:0] res_addr, last_addr;              // Arbiter address
  logic [1:0]  res_lanes, last_lanes;            // Arbiter lanes
  logic        cfg_valid, mode_generic, big_endian;
  int          gnt_dly = 2, gnt_cnt = 0, req_count = 0, lo_cnt = 0;
  int          err_total = 0, checked = 0;

  always #5 clk = ~clk;
  lcd_port_if bus ();
  lcd_ctrl_device lcd_ctrl_device_inst (.clk(clk), .rst_b(rst_b), .bus(bus),
    .config_straps(straps), .bus_status_strap(status_strap), .res_req(res_req),
    .res_write(res_write), .res_addr(res_addr), .res_lanes(res_lanes),
    .res_wdata(res_wdata), .res_grant(res_grant), .res_rdata(res_rdata),
    .cfg_valid(cfg_valid), .mode_generic(mode_generic), .big_endian(big_endian));
  lcd_host_port lcd_host_port_inst (.clk(clk), .rst_b(rst_b), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_word(cmd_word),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_miss(rsp_miss), .rsp_wide(rsp_wide),
    .rsp_rdata(rsp_rdata));
  lcd_port_checker lcd_port_checker_inst (.clk(clk), .rst_b(rst_b), .data(bus.data),
    .display_ctrl_select_n(bus.display_ctrl_select_n),
    .mem_read_strobe_n(bus.mem_read_strobe_n), .mem_write_strobe_n(bus.mem_write_strobe_n),
    .cycle_ready(bus.cycle_ready), .word_capable_ack_n(bus.word_capable_ack_n),
    .dev_data_oe_n(bus.dev_data_oe_n), .host_data_oe_n(bus.host_data_oe_n));

  // Arbiter model: slow grant on purpose, records what it was asked
  always @(posedge clk) begin
    res_grant <= 1'b0;
    if (res_req && !res_grant && gnt_cnt >= gnt_dly) begin
      res_grant   <= 1'b1;
      res_rdata   <= RD_PAT ^ res_addr[15:0];
      last_write  <= res_write;
      last_addr   <= res_addr;
      last_lanes  <= res_lanes;
      last_wdata  <= res_wdata;
      rdy_at_gnt  <= bus.cycle_ready;
      req_count   <= req_count + 1;
      gnt_cnt     <= 0;
    end else if (res_req && !res_grant) begin
      gnt_cnt <= gnt_cnt + 1;
    end else begin
      gnt_cnt <= 0;
    end
    if (!bus.cycle_ready) begin
      lo_cnt <= lo_cnt + 1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Reset with given straps; straps latch on the third clock after reset releases
  task automatic do_reset(input logic [3:0] s, input logic bs);
    @(posedge clk);
    rst_b  <= 1'b0;
    straps <= s;
    status_strap <= bs;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
  endtask

  // One command, waits for its response under a bound
  task automatic access(input logic wr, input logic wd, input logic [31:0] a,
                        input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    lo_cnt = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_word  <= wd;
    cmd_addr  <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) begin
      check("response", 32'h0, 32'h1);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200us;
    err_total++;
    results();
  end

  initial begin
    do_reset(4'h7, 1'b1);
    check("cfg", {cfg_valid, mode_generic, big_endian}, 32'h6);
    access(1'b0, 1'b1, 32'h1340_0000, 16'h0000);
    check("miss_hi", rsp_miss, 32'h1);
    access(1'b0, 1'b1, 32'h133D_FFFE, 16'h0000);
    check("miss_lo", rsp_miss, 32'h1);
    check("no_cycle", req_count, 32'h0);
    access(1'b1, 1'b1, 32'h133E_0002, 16'hBEEF);
    check("wr_kind", {last_write, last_lanes, rsp_miss}, 32'hE);
    check("wr_addr", last_addr, 32'h0_0002);
    check("wr_data", last_wdata, 32'hBEEF);
    check("wide", rsp_wide, 32'h1);
    access(1'b1, 1'b0, 32'h133F_FFFE, 16'h0055);
    check("byte_lanes", last_lanes, 32'h1);
    check("byte_addr", last_addr, 32'h1_FFFE);
    gnt_dly = 20;
    access(1'b0, 1'b1, 32'h133E_0010, 16'h0000);
    check("slow_rd", rsp_rdata, RD_PAT ^ 16'h0010);
    check("rdy_gnt", rdy_at_gnt, 32'h0);
    check("stretch", lo_cnt >= 20, 32'h1);
    gnt_dly = 2;
    for (int i = 0; i < 3; i++) begin
      access(1'b0, 1'b1, 32'h133F_0100 + 32'(i * 2), 16'h0000);
      check("rd_seq", rsp_rdata, RD_PAT ^ (16'h0100 + 16'(i * 2)));
    end
    do_reset(4'hF, 1'b1);
    check("cfg_be", {mode_generic, big_endian}, 32'h3);
    access(1'b1, 1'b1, 32'h133E_0004, 16'h1234);
    check("be_swap", last_wdata, 32'h3412);
    access(1'b0, 1'b1, 32'h133E_0008, 16'h0000);
    check("be_rd", rsp_rdata, 32'hCBC3);
    do_reset(4'h0, 1'b1);
    check("cfg_off", mode_generic, 32'h0);
    access(1'b1, 1'b1, 32'h133E_0006, 16'h0F0F);
    check("off_cycle", req_count, 32'h8);
    check("off_wide", rsp_wide, 32'h0);
    results();
  end
endmodule
